// [scl_pkg.sv]
/*
 Shared constants for the stream-to-context lookup: address map, field
 positions, sizes and reset values. Assumes a byte-addressed register
 port with 32-bit words and byte enables.
*/
package scl_pkg;
	localparam int ADDR_W       = 18;
	localparam int DATA_W       = 32;
	localparam int BYTE_W       = 8;
	localparam int LANES        = 4;
	localparam int WORD_LSB     = 2;
	localparam int SID_W        = 16;
	localparam int GRP_W        = 8;
	localparam int CTX_W        = 7;
	localparam int CNT_W        = 8;
	localparam int EXT_NUM_W    = 10;
	localparam int IDX_AW       = 14;
	localparam int TYPE_W       = 2;
	localparam int EXT_GROUPS   = 256;
	localparam int BASIC_GROUPS = 128;
	localparam int CTX_ENTRIES  = 128;
	localparam int IDX_WORDS    = 1 << IDX_AW;
	localparam int PAGE_BYTES   = 4096;
	localparam int PAGE_MULT    = 8;
	localparam int WORD_BYTES   = 4;
	// Region select: compare address bits above these positions
	localparam int EXT_SEL_LSB  = 12;
	localparam int BAS_SEL_LSB  = 9;
	localparam logic [GRP_W-1:0]  ALIAS_FIRST = GRP_W'(EXT_GROUPS - BASIC_GROUPS);
	localparam logic [ADDR_W-1:0] CFG1_ADDR   = 18'h00000;
	localparam logic [ADDR_W-1:0] CFG2_ADDR   = 18'h00004;
	localparam logic [ADDR_W-1:0] ID2_ADDR    = 18'h00008;
	localparam logic [ADDR_W-1:0] BSM_BASE    = 18'h00800;
	localparam logic [ADDR_W-1:0] BS2C_BASE   = 18'h00C00;
	localparam logic [ADDR_W-1:0] EXSM_BASE   = 18'h04000;
	localparam logic [ADDR_W-1:0] EXS2C_BASE  = 18'h05000;
	localparam logic [ADDR_W-1:0] IDX_BASE    = ADDR_W'(PAGE_MULT * PAGE_BYTES);
	localparam logic [ADDR_W-1:0] IDX_END     = ADDR_W'(PAGE_MULT * PAGE_BYTES
		+ WORD_BYTES * IDX_WORDS);
	// Field positions
	localparam int GLOBAL_SECURE_ONLY_ACCESS_BIT = 0;
	localparam int OWNER_BIT  = 1;
	localparam int NSCNT_LSB  = 8;
	localparam int EXTEN_BIT  = 0;
	localparam int CIEN_BIT   = 1;
	localparam int CAP_BIT    = 0;
	localparam int TYPE_LSB   = 16;
	localparam logic [BYTE_W-1:0] FIELD_MASK = BYTE_W'((1 << CTX_W) - 1);
	localparam logic [DATA_W-1:0] WORD_FIELD_MASK = {LANES{FIELD_MASK}};
	localparam logic [LANES-1:0]  BYTE_ALL     = 4'hF;
	localparam logic [DATA_W-1:0] WORD_ZERO    = 32'h00000000;
	localparam logic [DATA_W-1:0] UNKNOWN_WORD = 32'h00000000;
	localparam logic [CNT_W-1:0]  NS_CNT_RESET = 8'h80;
	localparam logic IMPL_MATCHING = 1'b1;
	localparam logic CAP_PRESENT   = 1'b1;
endpackage

// [scl_lookup.sv]
/*
 Stream-to-context lookup: extended match and context register groups
 with the basic view aliased on top, the compressed index table, the
 security configuration bits and a one-cycle transaction lookup.
 Assumes a single clock, a register master that never waits and marks
 each access Secure or Non-secure, and transactions already carrying
 their Security state.
*/
// Operation
// - Basic match and context groups reach the top 128 extended groups' storage.
// - Extended match and context registers take full 32-bit reads and writes.
// - Global secure-only bit set: extended registers reachable by Secure accesses only.
// - Extended groups beyond the implemented count read zero, drop writes.
// - Matching implementation: match registers read-write; indexing one: read zero.
// - Extended enable clear: unaliased groups of that state read unknown, drop writes.
// - Extended registers are 32-bit read-write with undefined contents after reset.
// - Context entry layout chosen by its two-bit type field, bits 17 to 16.
// - Index lookup accepts 16-bit stream identifiers, 0x0000 to 0xFFFF.
// - One state uses indexing, chosen by Secure bit resetting to Non-secure.
// - Capability bit: Secure reads one; Non-secure reads one only if it owns it.
// - Indexing active only once owner state's enable bit is written one.
// - Table word i/4 holds four byte fields; field i mod 4, field 0 lowest.
// - Missing or opposite-state entry makes the transaction unmatched.
// - Table undefined after reset; while disabled reads unknown, ignores writes.
// - Secure owner: table reads zero, ignores writes for Non-secure accesses.
// - Global secure-only bit: table reads zero, ignores Non-secure writes.
// - Table contiguous, word n at eight pages plus four times n.
// - Table words accept single-byte and full 32-bit accesses.
// - Field bit 7 reserved zero, plus unused high bits for small counts.
// - Indexing state never consults match registers; fields never act as identifiers.
// - Basic group p equals extended group N plus p minus 128.
module scl_lookup (
	input  wire logic                             core_clk,
	input  wire logic                             arst_n,
	input  wire logic [scl_pkg::ADDR_W-1:0]       bus_addr,
	input  wire logic [scl_pkg::DATA_W-1:0]       bus_wdata,
	input  wire logic [scl_pkg::LANES-1:0]        bus_be,
	input  wire logic                             bus_write,
	input  wire logic                             bus_read,
	input  wire logic                             bus_secure,
	output logic      [scl_pkg::DATA_W-1:0]       bus_rdata,
	input  wire logic                             txn_valid,
	input  wire logic [scl_pkg::SID_W-1:0]        txn_stream_id,
	input  wire logic                             txn_secure,
	output logic                                  ctx_valid,
	output logic                                  ctx_index_hit,
	output logic                                  ctx_no_match,
	output logic                                  ctx_to_matching,
	output logic      [scl_pkg::GRP_W-1:0]        ctx_entry,
	output logic      [scl_pkg::TYPE_W-1:0]       ctx_type
);
	// Storage left unreset on purpose: contents are undefined after reset
	logic [scl_pkg::DATA_W-1:0] ext_match [scl_pkg::EXT_GROUPS];
	logic [scl_pkg::DATA_W-1:0] ext_ctx   [scl_pkg::EXT_GROUPS];
	logic [scl_pkg::DATA_W-1:0] idx_table [scl_pkg::IDX_WORDS];

	logic                        global_secure_only_access;
	logic                        owner_secure;
	logic [scl_pkg::CNT_W-1:0]   ns_count;
	logic [1:0]                  ext_en;
	logic [1:0]                  ci_en;

	logic                        reg_hit;
	logic                        reg_is_ctx;
	logic                        reg_grp_ok;
	logic [scl_pkg::GRP_W-1:0]   reg_grp;
	logic                        aliased;
	logic                        ns_blocked;
	logic                        grp_enabled;
	logic                        reg_wr_ok;
	logic                        idx_hit;
	logic                        idx_raz;
	logic                        idx_on;
	logic                        idx_wr_ok;
	logic [scl_pkg::ADDR_W-1:0]  idx_ofs;
	logic [scl_pkg::IDX_AW-1:0]  idx_word;
	logic [scl_pkg::DATA_W-1:0]  idx_cur_word;
	logic [scl_pkg::EXT_NUM_W-1:0] ext_num;
	logic [scl_pkg::DATA_W-1:0]  next_rdata;
	logic                        be_single;

	// Address decode for the group views
	always_comb
	begin
		ext_num = bus_addr[scl_pkg::EXT_SEL_LSB-1:scl_pkg::WORD_LSB];
		reg_hit = 1'b0;
		reg_is_ctx = 1'b0;
		reg_grp_ok = 1'b0;
		reg_grp = '0;
		if (bus_addr[scl_pkg::ADDR_W-1:scl_pkg::EXT_SEL_LSB] ==
			scl_pkg::EXSM_BASE[scl_pkg::ADDR_W-1:scl_pkg::EXT_SEL_LSB] ||
			bus_addr[scl_pkg::ADDR_W-1:scl_pkg::EXT_SEL_LSB] ==
			scl_pkg::EXS2C_BASE[scl_pkg::ADDR_W-1:scl_pkg::EXT_SEL_LSB])
		begin
			reg_hit = 1'b1;
			reg_is_ctx = bus_addr[scl_pkg::EXT_SEL_LSB] ==
				scl_pkg::EXS2C_BASE[scl_pkg::EXT_SEL_LSB];
			reg_grp_ok = ext_num < scl_pkg::EXT_NUM_W'(scl_pkg::EXT_GROUPS);
			reg_grp = ext_num[scl_pkg::GRP_W-1:0];
		end
		else if (bus_addr[scl_pkg::ADDR_W-1:scl_pkg::BAS_SEL_LSB] ==
			scl_pkg::BSM_BASE[scl_pkg::ADDR_W-1:scl_pkg::BAS_SEL_LSB] ||
			bus_addr[scl_pkg::ADDR_W-1:scl_pkg::BAS_SEL_LSB] ==
			scl_pkg::BS2C_BASE[scl_pkg::ADDR_W-1:scl_pkg::BAS_SEL_LSB])
		begin
			// Basic view lands on the top groups
			reg_hit = 1'b1;
			reg_is_ctx = bus_addr[scl_pkg::BAS_SEL_LSB+1] ==
				scl_pkg::BS2C_BASE[scl_pkg::BAS_SEL_LSB+1];
			reg_grp_ok = 1'b1;
			reg_grp = scl_pkg::ALIAS_FIRST + scl_pkg::GRP_W'(
				bus_addr[scl_pkg::BAS_SEL_LSB-1:scl_pkg::WORD_LSB]);
		end
	end

	// Access gating for the group views
	always_comb
	begin
		aliased = reg_grp >= scl_pkg::ALIAS_FIRST;
		ns_blocked = !bus_secure && global_secure_only_access;
		grp_enabled = aliased || ext_en[bus_secure];
		reg_wr_ok = bus_write && reg_hit && reg_grp_ok && !ns_blocked
			&& grp_enabled
			&& (reg_is_ctx || scl_pkg::IMPL_MATCHING)
			&& bus_be == scl_pkg::BYTE_ALL;
	end

	// Table decode: contiguous run of words after eight pages
	always_comb
	begin
		idx_hit = bus_addr >= scl_pkg::IDX_BASE && bus_addr < scl_pkg::IDX_END;
		idx_ofs = bus_addr - scl_pkg::IDX_BASE;
		idx_word = idx_ofs[scl_pkg::IDX_AW+scl_pkg::WORD_LSB-1:scl_pkg::WORD_LSB];
		idx_cur_word = idx_table[idx_word];
		idx_raz = !bus_secure && (owner_secure || global_secure_only_access);
		idx_on = ci_en[owner_secure];
		be_single = $onehot(bus_be);
		idx_wr_ok = bus_write && idx_hit && !idx_raz && idx_on
			&& (bus_be == scl_pkg::BYTE_ALL || be_single);
	end

	// Read data mux; unmapped space reads zero
	always_comb
	begin
		next_rdata = scl_pkg::WORD_ZERO;
		if (reg_hit)
		begin
			if (!reg_grp_ok || ns_blocked || (!reg_is_ctx && !scl_pkg::IMPL_MATCHING))
				next_rdata = scl_pkg::WORD_ZERO;
			else if (!grp_enabled)
				next_rdata = scl_pkg::UNKNOWN_WORD;
			else if (reg_is_ctx)
				next_rdata = ext_ctx[reg_grp];
			else
				next_rdata = ext_match[reg_grp];
		end
		else if (idx_hit)
		begin
			if (idx_raz)
				next_rdata = scl_pkg::WORD_ZERO;
			else if (!idx_on)
				next_rdata = scl_pkg::UNKNOWN_WORD;
			else
				next_rdata = idx_cur_word;
		end
		else if (bus_addr == scl_pkg::CFG1_ADDR)
		begin
			if (bus_secure)
			begin
				next_rdata[scl_pkg::GLOBAL_SECURE_ONLY_ACCESS_BIT] = global_secure_only_access;
				next_rdata[scl_pkg::OWNER_BIT] = owner_secure;
				next_rdata[scl_pkg::NSCNT_LSB +: scl_pkg::CNT_W] = ns_count;
			end
		end
		else if (bus_addr == scl_pkg::CFG2_ADDR)
		begin
			next_rdata[scl_pkg::EXTEN_BIT] = ext_en[bus_secure];
			next_rdata[scl_pkg::CIEN_BIT] = ci_en[bus_secure];
		end
		else if (bus_addr == scl_pkg::ID2_ADDR)
			next_rdata[scl_pkg::CAP_BIT] = scl_pkg::CAP_PRESENT
				&& (bus_secure || !owner_secure);
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			bus_rdata <= scl_pkg::WORD_ZERO;
		else if (bus_read)
			bus_rdata <= next_rdata;
		else
			bus_rdata <= scl_pkg::WORD_ZERO;
	end

	// Secure-only configuration; Non-secure writes dropped
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			global_secure_only_access <= 1'b0;
			owner_secure <= 1'b0;
			ns_count <= scl_pkg::NS_CNT_RESET;
		end
		else if (bus_write && bus_secure && bus_addr == scl_pkg::CFG1_ADDR
			&& bus_be == scl_pkg::BYTE_ALL)
		begin
			global_secure_only_access <= bus_wdata[scl_pkg::GLOBAL_SECURE_ONLY_ACCESS_BIT];
			owner_secure <= bus_wdata[scl_pkg::OWNER_BIT];
			ns_count <= bus_wdata[scl_pkg::NSCNT_LSB +: scl_pkg::CNT_W];
		end
	end

	// Banked enables: each access reaches its own state's copy
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ext_en <= 2'h0;
			ci_en <= 2'h0;
		end
		else if (bus_write && bus_addr == scl_pkg::CFG2_ADDR
			&& bus_be == scl_pkg::BYTE_ALL)
		begin
			ext_en[bus_secure] <= bus_wdata[scl_pkg::EXTEN_BIT];
			ci_en[bus_secure] <= bus_wdata[scl_pkg::CIEN_BIT];
		end
	end

	// Group storage, whole words only
	always_ff @(posedge core_clk)
	begin
		if (reg_wr_ok && reg_is_ctx)
			ext_ctx[reg_grp] <= bus_wdata;
		if (reg_wr_ok && !reg_is_ctx)
			ext_match[reg_grp] <= bus_wdata;
	end

	// Table storage per byte lane; reserved field bits forced to zero
	always_ff @(posedge core_clk)
	begin
		for (int b = 0; b < scl_pkg::LANES; b++)
		begin
			if (idx_wr_ok && bus_be[b])
				idx_table[idx_word][b*scl_pkg::BYTE_W +: scl_pkg::BYTE_W] <=
					bus_wdata[b*scl_pkg::BYTE_W +: scl_pkg::BYTE_W]
					& scl_pkg::FIELD_MASK;
		end
	end

	logic                        use_idx;
	logic [scl_pkg::DATA_W-1:0]  lk_word;
	logic [scl_pkg::BYTE_W-1:0]  lk_field;
	logic [scl_pkg::CTX_W-1:0]   lk_p;
	logic                        lk_exists;
	logic                        lk_sec_res;
	logic                        lk_opposite;
	logic [scl_pkg::GRP_W-1:0]   lk_q;

	// Lookup: matching is bypassed entirely for the indexing state
	always_comb
	begin
		use_idx = txn_secure == owner_secure && ci_en[owner_secure];
		lk_word = idx_table[txn_stream_id[scl_pkg::SID_W-1:scl_pkg::WORD_LSB]];
		lk_field = lk_word[txn_stream_id[scl_pkg::WORD_LSB-1:0]*scl_pkg::BYTE_W
			+: scl_pkg::BYTE_W];
		lk_p = lk_field[scl_pkg::CTX_W-1:0] & scl_pkg::FIELD_MASK[scl_pkg::CTX_W-1:0];
		lk_exists = int'(lk_p) < scl_pkg::CTX_ENTRIES;
		lk_sec_res = {1'b0, lk_p} >= ns_count;
		lk_opposite = txn_secure ? !lk_sec_res : lk_sec_res;
		lk_q = scl_pkg::ALIAS_FIRST + scl_pkg::GRP_W'(lk_p);
	end

	// Registered answer, one cycle after each transaction
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctx_valid <= 1'b0;
			ctx_index_hit <= 1'b0;
			ctx_no_match <= 1'b0;
			ctx_to_matching <= 1'b0;
			ctx_entry <= '0;
			ctx_type <= '0;
		end
		else
		begin
			ctx_valid <= txn_valid;
			ctx_to_matching <= txn_valid && !use_idx;
			ctx_no_match <= txn_valid && use_idx && (!lk_exists || lk_opposite);
			ctx_index_hit <= txn_valid && use_idx && lk_exists && !lk_opposite;
			if (txn_valid && use_idx && lk_exists && !lk_opposite)
			begin
				ctx_entry <= lk_q;
				ctx_type <= ext_ctx[lk_q][scl_pkg::TYPE_LSB +: scl_pkg::TYPE_W];
			end
			else
			begin
				ctx_entry <= '0;
				ctx_type <= '0;
			end
		end
	end

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_basic_alias_write: assert property (
		reg_wr_ok && reg_is_ctx && aliased
		|=> ext_ctx[$past(reg_grp)] == $past(bus_wdata))
		else $error("aliased context write lost");
	a_partial_ext_drop: assert property (
		bus_write && reg_hit && bus_be != scl_pkg::BYTE_ALL |-> !reg_wr_ok)
		else $error("partial write reached group storage");
	a_secure_only_read: assert property (
		bus_read && reg_hit && !bus_secure && global_secure_only_access |=> bus_rdata == scl_pkg::WORD_ZERO)
		else $error("non-secure read leaked group data");
	a_unimpl_group_raz: assert property (
		bus_read && reg_hit && !reg_grp_ok |=> bus_rdata == scl_pkg::WORD_ZERO)
		else $error("unimplemented group not zero");
	a_disabled_unknown: assert property (
		bus_read && reg_hit && reg_grp_ok && !ns_blocked && !aliased
		&& !ext_en[bus_secure] |=> bus_rdata == scl_pkg::UNKNOWN_WORD)
		else $error("disabled group returned data");
	a_cap_ns_view: assert property (
		bus_read && bus_addr == scl_pkg::ID2_ADDR && !bus_secure && owner_secure
		|=> !bus_rdata[scl_pkg::CAP_BIT])
		else $error("capability shown to non-owner");
	a_idx_ns_raz: assert property (
		bus_read && idx_hit && !bus_secure && (owner_secure || global_secure_only_access)
		|=> bus_rdata == scl_pkg::WORD_ZERO)
		else $error("table visible to non-secure");
	// Table words start unknown, so the gate is checked rather than the storage
	a_idx_disabled_wi: assert property (
		bus_write && idx_hit && !idx_on |-> !idx_wr_ok)
		else $error("disabled table took a write");
	a_field_res0_read: assert property (
		bus_read && idx_hit && !idx_raz && idx_on
		|=> (bus_rdata & ~scl_pkg::WORD_FIELD_MASK) == scl_pkg::WORD_ZERO)
		else $error("reserved field bit set");
	a_lookup_onehot: assert property (
		txn_valid |=> ctx_valid && $onehot({ctx_index_hit, ctx_no_match, ctx_to_matching}))
		else $error("lookup answer malformed");
	a_idx_bypass_match: assert property (
		txn_valid && txn_secure == owner_secure && ci_en[owner_secure]
		|=> !ctx_to_matching)
		else $error("indexing state sent to matching");
	a_opposite_nomatch: assert property (
		txn_valid && use_idx && lk_opposite |=> ctx_no_match && ctx_entry == '0)
		else $error("opposite-state entry selected");
	// Table access, owner bit and lookup gating
	a_idx_byte_accept: assert property (
		bus_write && idx_hit && !idx_raz && idx_on && $onehot(bus_be) |-> idx_wr_ok)
		else $error("single-lane table write refused");
	a_idx_gas_raz: assert property (
		bus_read && idx_hit && !bus_secure && global_secure_only_access
		|=> bus_rdata == scl_pkg::WORD_ZERO)
		else $error("table visible under secure-only");
	a_owner_ns_keep: assert property (
		bus_write && !bus_secure && bus_addr == scl_pkg::CFG1_ADDR
		|=> $stable(owner_secure))
		else $error("non-secure write moved the owner");
	a_idx_enable_gate: assert property (
		txn_valid && !ci_en[owner_secure] |=> ctx_to_matching)
		else $error("indexing used before its enable");
	a_hit_entry_range: assert property (
		ctx_index_hit |-> ctx_entry >= scl_pkg::ALIAS_FIRST)
		else $error("indexed entry outside aliased groups");

	c_index_hit: cover property (txn_valid && use_idx ##1 ctx_index_hit);
	c_no_match: cover property (ctx_no_match);
	c_alias_write: cover property (reg_wr_ok && aliased);
	c_byte_write: cover property (idx_wr_ok && be_single);
	c_secure_owner_hit: cover property (txn_valid && txn_secure && use_idx ##1 ctx_index_hit);
endmodule

// [scl_client.sv]
/*
 Client master model: presents one tagged transaction per requested cycle.
 Assumes the bench raises requests by non-blocking assignment after a clock edge.
*/
module scl_client (
	input  wire logic                       core_clk,
	input  wire logic                       arst_n,
	input  wire logic                       req,
	input  wire logic [scl_pkg::SID_W-1:0]  req_sid,
	input  wire logic                       req_sec,
	output logic                            txn_valid,
	output logic      [scl_pkg::SID_W-1:0]  txn_stream_id,
	output logic                            txn_secure
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [scl_pkg::SID_W-1:0] junk;
	// Idle lines wander so a stale identifier never looks like a request
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			junk <= 16'hA5A5;
		else
			junk <= ~junk + 16'h0001;
	// Requests pass straight through, full identifier width
	assign txn_valid     = req;
	assign txn_stream_id = req ? req_sid : junk;
	assign txn_secure    = req ? req_sec : junk[0];
endmodule

// [scl_lookup_tb.sv]
/*
 Self-checking bench for the stream-to-context lookup: register model, lookup
 model and client traffic. Assumes a register port with no wait states.
*/
module scl_lookup_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [17:0] bus_addr = 18'h00000;
	logic [31:0] bus_wdata = 32'h00000000;
	logic [3:0]  bus_be = 4'h0;
	logic        bus_write = 1'b0;
	logic        bus_read = 1'b0;
	logic        bus_secure = 1'b0;
	logic [31:0] bus_rdata;
	logic        req = 1'b0;
	logic [15:0] req_sid = 16'h0000;
	logic        req_sec = 1'b0;
	logic        txn_valid, txn_secure, ctx_valid, ctx_index_hit, ctx_no_match, ctx_to_matching;
	logic [15:0] txn_stream_id;
	logic [7:0]  ctx_entry;
	logic [1:0]  ctx_type;
	int          num_errors = 0;
	int          n_checks = 0;
	// Model state: config bits, tables keyed by word or kind and group
	logic        gas = 1'b0;
	logic        own = 1'b0;
	int          nsc = 128;
	logic [1:0]  exen = 2'h0;
	logic [1:0]  cen = 2'h0;
	logic [31:0] tbl [int];
	logic [31:0] grp [int];
	logic [12:0] expq [$];

	scl_client scl_client_inst (.core_clk(core_clk), .arst_n(arst_n), .req(req),
		.req_sid(req_sid), .req_sec(req_sec), .txn_valid(txn_valid),
		.txn_stream_id(txn_stream_id), .txn_secure(txn_secure));
	scl_lookup scl_lookup_inst (.core_clk(core_clk), .arst_n(arst_n), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_be(bus_be), .bus_write(bus_write), .bus_read(bus_read),
		.bus_secure(bus_secure), .bus_rdata(bus_rdata), .txn_valid(txn_valid),
		.txn_stream_id(txn_stream_id), .txn_secure(txn_secure), .ctx_valid(ctx_valid),
		.ctx_index_hit(ctx_index_hit), .ctx_no_match(ctx_no_match),
		.ctx_to_matching(ctx_to_matching), .ctx_entry(ctx_entry), .ctx_type(ctx_type));

	// 10 MHz clock
	always #50 core_clk = ~core_clk;

	// One register access on the model: returns read value, applies write
	function automatic logic [31:0] m_acc(input int a, input logic s, input logic w,
		input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		int          g;
		int          k;
		int          n;
		r = 32'h00000000;
		g = -1;
		k = (a >= 32'h5000 && a < 32'h6000 || a >= 32'hC00 && a < 32'hE00) ? 1024 : 0;
		if (a == 0 && s)
		begin
			if (w)
				{nsc, own, gas} = {d[15:8], d[1:0]};
			r = {16'h0000, 8'(nsc), 6'h00, own, gas};
		end
		else if (a == 4)
		begin
			if (w)
				{cen[s], exen[s]} = d[1:0];
			r = {30'h00000000, cen[s], exen[s]};
		end
		else if (a == 8)
			r = {31'h00000000, s | !own};
		else if (a >= 32'h800 && a < 32'hA00 || a >= 32'hC00 && a < 32'hE00)
			g = 128 + (a & 32'h1FF) / 4;
		else if (a >= 32'h4000 && a < 32'h6000)
			g = (a & 32'hFFF) / 4;
		else if (a >= 32'h8000 && a < 32'h18000 && (s || !own && !gas) && cen[own])
		begin
			n = (a - 32'h8000) / 4;
			r = tbl[n];
			if (w && be == 4'hF)
				tbl[n] = d & 32'h7F7F7F7F;
			else if (w && $onehot(be))
				for (int b = 0; b < 4; b++)
					if (be[b])
						tbl[n][8*b+:8] = d[8*b+:8] & 8'h7F;
		end
		if (g >= 0 && g < 256 && (s || !gas) && (g >= 128 || exen[s]))
		begin
			r = grp[k + g];
			if (w && be == 4'hF)
				grp[k + g] = d;
		end
		return r;
	endfunction

	// Expected {hit, no_match, to_matching, entry, type} for one transaction
	function automatic logic [12:0] m_look(input logic [15:0] sid, input logic s);
		int p;
		p = tbl[sid >> 2][8 * sid[1:0] +: 7];
		if (s != own || !cen[own])
			return 13'h0400;
		if ((p >= nsc) != s)
			return 13'h0800;
		return {3'h4, 8'(128 + p), grp[1152 + p][17:16]};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wr(input int a, input logic [31:0] d, input logic s, input logic [3:0] be = 4'hF);
		void'(m_acc(a, s, 1'b1, d, be));
		@(posedge core_clk);
		{bus_write, bus_addr, bus_wdata, bus_be, bus_secure} <= {1'b1, 18'(a), d, be, s};
		@(posedge core_clk);
		bus_write <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input int a, input logic s);
		logic [31:0] e;
		e = m_acc(a, s, 1'b0, 32'h00000000, 4'h0);
		@(posedge core_clk);
		{bus_read, bus_addr, bus_secure} <= {1'b1, 18'(a), s};
		@(posedge core_clk);
		bus_read <= 1'b0;
		#1 chk(bus_rdata, e);
	endtask

	task automatic send(input logic [15:0] sid, input logic s);
		@(posedge core_clk);
		{req, req_sid, req_sec} <= {1'b1, sid, s};
		expq.push_back(m_look(sid, s));
	endtask

	// Back-to-back random traffic, then a bounded drain of predictions
	task automatic burst(input int n, input int span);
		for (int i = 0; i < n; i++)
			send(16'($urandom_range(span - 1)), 1'($urandom));
		@(posedge core_clk);
		req <= 1'b0;
		for (int i = 0; i < 10 && expq.size() > 0; i++)
			@(posedge core_clk);
		if (expq.size() > 0)
		begin
			num_errors++;
			test_done();
		end
	endtask

	// Every delivered context is held against the oldest prediction
	always @(posedge core_clk)
		if (ctx_valid === 1'b1)
		begin
			if (expq.size() == 0)
				chk(32'h1, 32'h0);
			else
				chk(32'({ctx_index_hit, ctx_no_match, ctx_to_matching, ctx_entry, ctx_type}),
					32'(expq.pop_front()));
		end

	initial
	begin
		void'($urandom(47));
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		// Reset configuration and capability views
		rd(0, 1'b1);
		rd(0, 1'b0);
		rd(8, 1'b1);
		rd(8, 1'b0);
		// Table closed, unaliased groups gated, unimplemented groups empty
		wr(32'h8000, 32'h01020304, 1'b1);
		rd(32'h8000, 1'b1);
		wr(32'h4014, 32'h12345678, 1'b0);
		rd(32'h4014, 1'b0);
		wr(32'h5000 + 4 * 300, 32'hFFFFFFFF, 1'b1);
		rd(32'h5000 + 4 * 300, 1'b1);
		// Aliased contexts via both views; only type and low bits, no override
		for (int p = 0; p < 128; p++)
			wr(p[0] ? 32'hC00 + 4 * p : 32'h5000 + 4 * (128 + p),
				$urandom & 32'h00030000 | 32'(p), 1'b1);
		for (int p = 0; p < 128; p += 37)
		begin
			rd(32'h5000 + 4 * (128 + p), 1'b0);
			rd(32'hC00 + 4 * p, 1'b1);
		end
		wr(32'h5000 + 4 * 130, 32'hFFFFFFFF, 1'b1, 4'h3);
		rd(32'hC08, 1'b1);
		wr(32'h4000 + 4 * 200, 32'hCAFE0001, 1'b0);
		rd(32'h800 + 4 * 72, 1'b0);
		// Non-secure enables indexing and its extended groups
		wr(4, 32'h3, 1'b0);
		wr(32'h4014, 32'h12345678, 1'b0);
		rd(32'h4014, 1'b0);
		rd(32'h4014, 1'b1);
		for (int n = 0; n < 8; n++)
			wr(32'h8000 + 4 * n, $urandom, 1'b0);
		rd(32'h8004, 1'b0);
		for (int b = 0; b < 4; b++)
			wr(32'h8020, $urandom, 1'b0, 4'(1 << b));
		wr(32'h8020, 32'hFFFFFFFF, 1'b0, 4'h3);
		rd(32'h8020, 1'b0);
		wr(32'h8000 + 4 * 16383, 32'hD5000000, 1'b0);
		rd(32'h8000 + 4 * 16383, 1'b1);
		send(16'hFFFF, 1'b0);
		burst(40, 36);
		// Upper entries reserved for Secure
		wr(0, 32'h1000, 1'b1);
		burst(40, 36);
		// Secure owns indexing, active only once its enable is written
		wr(0, 32'h1002, 1'b1);
		rd(32'h8000, 1'b0);
		rd(8, 1'b0);
		burst(20, 36);
		wr(4, 32'h2, 1'b1);
		rd(32'h8000, 1'b1);
		burst(40, 36);
		// Global secure-only bit closes both regions to Non-secure
		wr(0, 32'h1003, 1'b1);
		rd(32'hC00, 1'b0);
		rd(32'h8004, 1'b0);
		rd(32'h8004, 1'b1);
		// Secure-only bit alone, table owned by Non-secure
		wr(0, 32'h1001, 1'b1);
		rd(32'h8004, 1'b0);
		wr(0, 32'h0002, 1'b0);
		rd(0, 1'b1);
		test_done();
	end
endmodule
